// file: dsag_pkg.sv
// package for the data space address generation block
package dsag_pkg;
  localparam int DSAG_WREG_NUM = 16;
  localparam int DSAG_WREG_W = 16;
  localparam int DSAG_SP_IDX = 15;
  localparam int DSAG_PC_W = 23;
  localparam int DSAG_INSN_W = 24;
  localparam int DSAG_EA_W = 16;
  localparam int DSAG_PAGE_W = 9;
  localparam int DSAG_EDS_W = 24;
  localparam int DSAG_PSV_PAGE_W = 8;
  localparam logic [15:0] DSAG_SP_RESET = 16'h1000;
  localparam logic [22:0] DSAG_PC_RESET = 23'h000000;
  localparam logic [15:0] DSAG_WORD_STEP = 16'h0002;
  localparam logic [22:0] DSAG_PC_STEP = 23'h000002;
  localparam int DSAG_UPPER_BIT = 15;
  localparam logic [1:0] DSAG_PSV_EXTRA = 2'h1;
  localparam logic [1:0] DSAG_DWM_EXTRA = 2'h1;
  localparam logic [1:0] DSAG_FLOW_EXTRA = 2'h1;

  // address update mode of one generator
  typedef enum logic [1:0] {
    DSAG_UPD_NONE,
    DSAG_UPD_LINEAR,
    DSAG_UPD_MODULO,
    DSAG_UPD_BITREV
  } dsag_upd_t;

  // operation requested by decode
  typedef enum logic [2:0] {
    DSAG_OP_NOP,
    DSAG_OP_WRITE_REG,
    DSAG_OP_ACCESS,
    DSAG_OP_DUAL,
    DSAG_OP_PUSH,
    DSAG_OP_POP,
    DSAG_OP_BRANCH,
    DSAG_OP_DWMOVE
  } dsag_op_t;

  // one request from decode
  typedef struct packed {
    logic valid;
    dsag_op_t op;
    logic is_write;
    logic [3:0] x_reg;
    logic [3:0] y_reg;
    logic [3:0] dst_reg;
    logic [15:0] offset;
    logic [15:0] wdata;
    dsag_upd_t x_upd;
    dsag_upd_t y_upd;
    logic [22:0] target;
  } dsag_req_t;

  // window and page configuration
  typedef struct packed {
    logic psv_en;
    logic [7:0] psv_page;
    logic [8:0] rd_page;
    logic [8:0] wr_page;
    logic [15:0] x_mod_start;
    logic [15:0] x_mod_end;
    logic [15:0] y_mod_start;
    logic [15:0] y_mod_end;
    logic [15:0] bitrev_mod;
  } dsag_cfg_t;

  // one generated memory access
  typedef struct packed {
    logic valid;
    logic is_write;
    logic to_prog;
    logic [23:0] addr;
  } dsag_acc_t;
endpackage

// file: dsag_core.sv
// register file and address generators of the data space front end
`timescale 1ns/100ps

module dsag_core
  import dsag_pkg::*;
#(
  parameter bit HAS_DSP = 1'b1
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire dsag_req_t req,
  input wire dsag_cfg_t cfg,
  input wire logic [23:0] insn_word,
  input wire logic loop_active,
  input wire logic [22:0] loop_start,
  input wire logic loop_end_hit,
  input wire logic irq_take,
  input wire logic [22:0] irq_vector,
  output logic busy,
  output logic [22:0] pc,
  output logic [23:0] insn_out,
  output dsag_acc_t x_acc,
  output dsag_acc_t y_acc,
  output logic [15:0] x_data,
  output logic [15:0] stack_pointer_reg
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [DSAG_WREG_NUM-1:0][15:0] wreg;
    logic [22:0] pc;
    logic [23:0] insn;
    logic [1:0] stall;
    dsag_acc_t x_acc;
    dsag_acc_t y_acc;
    logic [15:0] x_data;
  } dsag_state_t;

  dsag_state_t st;
  dsag_state_t next_st;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // modulo wrap keeps pointer inside the buffer without software checks
  function automatic logic [15:0] dsag_modulo(input logic [15:0] ea,
      input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0] nxt;
    nxt = ea + DSAG_WORD_STEP;
    if (ea == hi - 16'h0001 || nxt > hi) begin
      return lo;
    end
    return nxt;
  endfunction

  // reverse-carry add for radix-2 reordering
  function automatic logic [15:0] dsag_bitrev(input logic [15:0] ea,
      input logic [15:0] modv);
    logic [15:0] ra;
    logic [15:0] rm;
    logic [15:0] rs;
    ra = {<<{ea}};
    rm = {<<{modv}};
    rs = ra + rm;
    return {<<{rs}};
  endfunction

  // one generator's post-update, reduced variant drops modulo and bit-reverse
  function automatic logic [15:0] dsag_update(input logic [15:0] ea,
      input dsag_upd_t upd, input logic [15:0] lo, input logic [15:0] hi,
      input logic [15:0] modv, input logic allow_br);
    logic [15:0] r;
    r = ea;
    unique case (upd)
      DSAG_UPD_NONE: r = ea;
      DSAG_UPD_LINEAR: r = ea + DSAG_WORD_STEP;
      DSAG_UPD_MODULO: r = HAS_DSP ? dsag_modulo(ea, lo, hi) : ea + DSAG_WORD_STEP;
      DSAG_UPD_BITREV: r = (HAS_DSP && allow_br) ? dsag_bitrev(ea, modv)
                                                : ea + DSAG_WORD_STEP;
    endcase
    return r;
  endfunction

  // map a 16-bit effective address to data or program window
  function automatic dsag_acc_t dsag_map(input logic [15:0] ea, input logic wr,
      input dsag_cfg_t c);
    dsag_acc_t a;
    a.valid = 1'b1;
    a.is_write = wr;
    if (c.psv_en && ea[DSAG_UPPER_BIT] && !wr) begin
      // window base on any 32 Kbyte aligned program boundary
      a.to_prog = 1'b1;
      a.addr = {1'b0, c.psv_page, ea[14:0]};
    end else begin
      // lower half, writes or window off stay in data memory
      a.to_prog = 1'b0;
      a.addr = ea[DSAG_UPPER_BIT] ?
               {wr ? c.wr_page : c.rd_page, ea[14:0]} :
               {8'h00, ea};
    end
    return a;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [15:0] xea;
    logic [15:0] yea;
    logic [15:0] spv;
    logic [1:0] extra;
    xea = 16'h0000;
    yea = 16'h0000;
    spv = 16'h0000;
    extra = 2'h0;
    next_st = st;
    next_st.x_acc = '0;
    next_st.y_acc = '0;
    spv = st.wreg[DSAG_SP_IDX];
    if (st.stall != 2'h0) begin
      // extra cycles of window, double move or flow change
      next_st.stall = st.stall - 2'h1;
    end else if (irq_take) begin
      // interrupt may cut a loop at any iteration
      next_st.wreg[DSAG_SP_IDX] = spv + DSAG_WORD_STEP;
      next_st.x_acc = dsag_map(spv, 1'b1, cfg);
      next_st.x_data = st.pc[15:0];
      next_st.pc = irq_vector;
      next_st.stall = DSAG_FLOW_EXTRA;
    end else begin
      // fetch a full 24-bit instruction word
      next_st.insn = insn_word;
      if (loop_active && loop_end_hit) begin
        next_st.pc = loop_start;
      end else begin
        next_st.pc = st.pc + DSAG_PC_STEP;
      end
      if (req.valid) begin
        xea = st.wreg[req.x_reg] + req.offset;
        yea = st.wreg[req.y_reg];
        unique case (req.op)
          DSAG_OP_NOP: extra = 2'h0;
          DSAG_OP_WRITE_REG: next_st.wreg[req.dst_reg] = req.wdata;
          DSAG_OP_ACCESS: begin
            // general class: X generator only, one linear space
            next_st.x_acc = dsag_map(xea, req.is_write, cfg);
            next_st.x_data = req.wdata;
            next_st.wreg[req.x_reg] = dsag_update(st.wreg[req.x_reg], req.x_upd,
                cfg.x_mod_start, cfg.x_mod_end, cfg.bitrev_mod, 1'b1);
          end
          DSAG_OP_DUAL: begin
            if (HAS_DSP) begin
              // two operand read through both generators
              next_st.x_acc = dsag_map(xea, 1'b0, cfg);
              next_st.y_acc = dsag_map(yea, 1'b0, cfg);
              next_st.wreg[req.x_reg] = dsag_update(st.wreg[req.x_reg], req.x_upd,
                  cfg.x_mod_start, cfg.x_mod_end, cfg.bitrev_mod, 1'b1);
              next_st.wreg[req.y_reg] = dsag_update(st.wreg[req.y_reg], req.y_upd,
                  cfg.y_mod_start, cfg.y_mod_end, cfg.bitrev_mod, 1'b0);
            end
            // reduced variant ignores signal-processing class
          end
          DSAG_OP_PUSH: begin
            next_st.x_acc = dsag_map(spv, 1'b1, cfg);
            next_st.x_data = req.wdata;
            next_st.wreg[DSAG_SP_IDX] = spv + DSAG_WORD_STEP;
          end
          DSAG_OP_POP: begin
            next_st.x_acc = dsag_map(spv - DSAG_WORD_STEP, 1'b0, cfg);
            next_st.wreg[DSAG_SP_IDX] = spv - DSAG_WORD_STEP;
          end
          DSAG_OP_BRANCH: begin
            next_st.pc = req.target;
            extra = DSAG_FLOW_EXTRA;
          end
          DSAG_OP_DWMOVE: begin
            next_st.x_acc = dsag_map(xea, req.is_write, cfg);
            next_st.x_data = req.wdata;
            extra = DSAG_DWM_EXTRA;
          end
        endcase
        if (next_st.x_acc.valid && next_st.x_acc.to_prog) begin
          extra = DSAG_PSV_EXTRA;
        end
        next_st.stall = extra;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st <= '0;
      st.wreg[DSAG_SP_IDX] <= DSAG_SP_RESET;
      st.pc <= DSAG_PC_RESET;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign busy = (st.stall != 2'h0);
  assign pc = st.pc;
  assign insn_out = st.insn;
  assign x_acc = st.x_acc;
  assign y_acc = st.y_acc;
  assign x_data = st.x_data;
  assign stack_pointer_reg = st.wreg[DSAG_SP_IDX];

endmodule // dsag_core

// file: dsag_checker.sv
// assertion checker for the data space address front end
`timescale 1ns/100ps
module dsag_checker
  import dsag_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire dsag_req_t req,
  input wire dsag_cfg_t cfg,
  input wire logic [23:0] insn_word,
  input wire logic loop_active,
  input wire logic [22:0] loop_start,
  input wire logic loop_end_hit,
  input wire logic irq_take,
  input wire logic [22:0] irq_vector,
  input wire logic busy,
  input wire logic [22:0] pc,
  input wire logic [23:0] insn_out,
  input wire dsag_acc_t x_acc,
  input wire dsag_acc_t y_acc,
  input wire logic [15:0] stack_pointer_reg
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // -------------------------------------------------
  // sequences and properties
  // -------------------------------------------------
  // a window access stalls for exactly one cycle
  sequence stall_s;
    busy ##1 !busy;
  endsequence
  reset_vals_a: assert property ($fell(srst) |-> stack_pointer_reg == DSAG_SP_RESET
    && pc == DSAG_PC_RESET) else $error("reset values wrong");
  win_stall_a: assert property (x_acc.valid && x_acc.to_prog |-> stall_s)
    else $error("window stall wrong");
  win_page_a: assert property (x_acc.valid && x_acc.to_prog |-> !x_acc.is_write
    && x_acc.addr[23:15] == {1'b0, $past(cfg.psv_page)}) else $error("window page wrong");
  x_cause_a: assert property (x_acc.valid |-> $past(req.valid) || $past(irq_take))
    else $error("x access without request");
  y_dual_a: assert property (y_acc.valid |-> $past(req.valid)
    && $past(req.op) == DSAG_OP_DUAL) else $error("y access without dual");
  loop_jump_a: assert property (loop_active && loop_end_hit && !busy && !irq_take
    && !req.valid |=> pc == $past(loop_start)) else $error("loop jump wrong");
  irq_vec_a: assert property (irq_take && !busy |=> pc == $past(irq_vector)
    && stack_pointer_reg != $past(stack_pointer_reg)) else $error("interrupt entry wrong");
  fetch_a: assert property (!busy && !irq_take |=> insn_out == $past(insn_word))
    else $error("fetch latch wrong");
endmodule // dsag_checker

bind dsag_core dsag_checker chk (.ref_clk, .srst, .req, .cfg, .insn_word, .loop_active,
  .loop_start, .loop_end_hit, .irq_take, .irq_vector, .busy, .pc, .insn_out, .x_acc,
  .y_acc, .stack_pointer_reg);

// file: dsag_prog_mem.sv
// program memory model feeding instruction words to the core
`timescale 1ns/100ps
module dsag_prog_mem
  import dsag_pkg::*;
(
  input wire logic [22:0] pc,
  output logic [23:0] insn_word
);
  // content follows the address so a stale fetch shows up
  assign insn_word = {pc, 1'b1} ^ 24'ha5c3e1;
endmodule // dsag_prog_mem

// file: tb.sv
// self-checking testbench for the data space address front end
`timescale 1ns/100ps
module tb
  import dsag_pkg::*;
;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  dsag_req_t req = '0;
  dsag_cfg_t cfg = '0;
  logic loop_active = 1'b0;
  logic [22:0] loop_start = 23'h0;
  logic loop_end_hit = 1'b0;
  logic irq_take = 1'b0;
  logic [22:0] irq_vector = 23'h0;
  logic busy;
  logic [22:0] pc;
  logic [23:0] insn_word;
  logic [23:0] insn_out;
  dsag_acc_t x_acc;
  dsag_acc_t y_acc;
  logic [15:0] x_data;
  logic [15:0] stack_pointer_reg;
  int fail_count = 0;
  int checks = 0;
  // -------------------------------------------------
  // clock and units
  // -------------------------------------------------
  always #4 ref_clk = ~ref_clk;
  dsag_core dut (.ref_clk, .srst, .req, .cfg, .insn_word, .loop_active, .loop_start,
    .loop_end_hit, .irq_take, .irq_vector, .busy, .pc, .insn_out, .x_acc, .y_acc, .x_data,
    .stack_pointer_reg);
  dsag_prog_mem pmem (.pc, .insn_word);
  // -------------------------------------------------
  // shared tasks
  // -------------------------------------------------
  task chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one request, held until the taking edge; busy wait is bounded
  task issue(input dsag_op_t op, input logic w, input logic [15:0] ea);
    int n;
    for (n = 0; n < 4 && busy !== 1'b0; n++) @(posedge ref_clk);
    if (n == 4) begin
      fail_count++;
      end_of_test;
    end
    @(posedge ref_clk);
    req.valid <= 1'b1;
    req.op <= op;
    req.is_write <= w;
    req.offset <= ea;
    req.y_reg <= 4'h1;
    @(posedge ref_clk);
    req.valid <= 1'b0;
    #1;
  endtask
  // register 0 is zero after reset, so the offset is the address
  task acc(input logic w, input logic [15:0] ea, input logic [23:0] ad, input logic pr);
    issue(DSAG_OP_ACCESS, w, ea);
    chk("addr", x_acc.addr, ad);
    chk("flags", 24'({x_acc.valid, x_acc.to_prog, busy}), 24'({1'b1, pr, pr}));
  endtask
  // -------------------------------------------------
  // scenarios
  // -------------------------------------------------
  task t_reset;
    chk("sp", 24'(stack_pointer_reg), 24'h001000);
    chk("pc", 24'(pc), 24'h0);
    $display("test reset done");
  endtask
  task t_space;
    acc(1'b0, 16'h1234, 24'h001234, 1'b0);
    acc(1'b1, 16'h7ffe, 24'h007ffe, 1'b0);
    acc(1'b0, 16'h8004, {9'h05a, 15'h0004}, 1'b1);
    acc(1'b0, 16'hfffe, {9'h05a, 15'h7ffe}, 1'b1);
    acc(1'b1, 16'h8010, {9'h0c5, 15'h0010}, 1'b0);
    @(posedge ref_clk);
    cfg.psv_en <= 1'b0;
    acc(1'b0, 16'h8010, {9'h1a3, 15'h0010}, 1'b0);
    $display("test space done");
  endtask
  task t_dual;
    issue(DSAG_OP_DUAL, 1'b0, 16'h0100);
    chk("y valid", 24'(y_acc.valid), 24'h1);
    chk("x addr", x_acc.addr, 24'h000100);
    $display("test dual done");
  endtask
  // push then pop through the stack pointer, write data must follow
  task t_stack;
    @(posedge ref_clk);
    req.wdata <= 16'hbeef;
    issue(DSAG_OP_PUSH, 1'b1, 16'h0000);
    chk("push addr", x_acc.addr, 24'h001000);
    chk("push data", 24'(x_data), 24'h00beef);
    chk("push sp", 24'(stack_pointer_reg), 24'h001002);
    issue(DSAG_OP_POP, 1'b0, 16'h0000);
    chk("pop addr", x_acc.addr, 24'h001000);
    chk("pop sp", 24'(stack_pointer_reg), 24'h001000);
    $display("test stack done");
  endtask
  // register 2 as address, linear post-increment, then a modulo wrap
  task t_modes;
    @(posedge ref_clk);
    req.dst_reg <= 4'h2;
    req.wdata <= 16'h0100;
    cfg.x_mod_start <= 16'h0100;
    cfg.x_mod_end <= 16'h0104;
    issue(DSAG_OP_WRITE_REG, 1'b0, 16'h0000);
    req.x_reg <= 4'h2;
    req.x_upd <= DSAG_UPD_LINEAR;
    issue(DSAG_OP_ACCESS, 1'b0, 16'h0000);
    chk("reg addr", x_acc.addr, 24'h000100);
    req.x_upd <= DSAG_UPD_MODULO;
    issue(DSAG_OP_ACCESS, 1'b0, 16'h0000);
    chk("lin addr", x_acc.addr, 24'h000102);
    issue(DSAG_OP_ACCESS, 1'b0, 16'h0000);
    chk("mod end", x_acc.addr, 24'h000104);
    issue(DSAG_OP_ACCESS, 1'b0, 16'h0000);
    chk("mod wrap", x_acc.addr, 24'h000100);
    req.x_reg <= 4'h0;
    req.x_upd <= DSAG_UPD_NONE;
    @(posedge ref_clk);
    $display("test modes done");
  endtask
  // loop end jump, then an interrupt in mid-loop
  task t_loop;
    @(posedge ref_clk);
    loop_active <= 1'b1;
    loop_start <= 23'h000100;
    loop_end_hit <= 1'b1;
    @(posedge ref_clk);
    loop_end_hit <= 1'b0;
    #1;
    chk("loop pc", 24'(pc), 24'h000100);
    @(posedge ref_clk);
    irq_take <= 1'b1;
    irq_vector <= 23'h000200;
    #1;
    chk("step pc", 24'(pc), 24'h000102);
    chk("insn", insn_out, {23'h000100, 1'b1} ^ 24'ha5c3e1);
    @(posedge ref_clk);
    irq_take <= 1'b0;
    loop_active <= 1'b0;
    #1;
    chk("irq pc", 24'(pc), 24'h000200);
    $display("test loop done");
  endtask
  // -------------------------------------------------
  // main sequence and hang guard
  // -------------------------------------------------
  initial begin
    cfg.psv_en = 1'b1;
    cfg.psv_page = 8'h5a;
    cfg.rd_page = 9'h1a3;
    cfg.wr_page = 9'h0c5;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    t_reset;
    t_space;
    t_stack;
    t_dual;
    t_modes;
    t_loop;
    end_of_test;
  end
  initial begin
    #100000;
    fail_count++;
    end_of_test;
  end
endmodule // tb
